// file: hw/lcc_top.v
// Contract
// RL1: Access-rights bytes 80h and 00h are always invalid descriptors.
// RL2: Lock is legal only on bit-test-modify, exchange and arithmetic ops.
// RL3: Lock before any other instruction raises invalid opcode, vector 6.
// RL4: Lock on a legal op with a register destination also raises vector 6.
// RL5: Register-memory swap always runs a locked access, prefix or not.
// RL6: A locked access locks at least its destination operand area.
// RL7: Lock use is never checked against the I/O privilege level.
// RL8: Base plus offset past 16 MB carries into higher bits, no wrap.
// RL9: With paging on, page faults, vector 14, reach legacy tasks too.
// RL10: Switching to a legacy task leaves the page directory base as is.
// RL11: Alignment checking needs flag bit 18 and the control mask bit.
// RL12: With checking on, an unaligned reference raises vector 17.
// RL13: Descriptor loads set the accessed bit locked only if it was clear.
// RL14: The top descriptor word supplies upper base and limit bits.
// RL15: The bus lock stays asserted from read through write of a locked op.
// RL16: Lock legality is decided in decode before any memory access.
`timescale 1ns/1ps
`include "lcc_defines.vh"

module lcc_top (
    // Clock and reset
    input wire clk_i,
    input wire rst_i,
    // Wishbone slave
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [7:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    // Decoded instruction
    input wire dec_valid_i,
    input wire [4:0] dec_op_i,
    input wire dec_lock_i,
    input wire dec_dst_reg_i,
    input wire [31:0] dec_addr_i,
    output reg dec_ready_o,
    output reg dec_accept_o,
    // Execution read and write halves of a locked op
    input wire [31:0] exe_wdata_i,
    input wire exe_wvalid_i,
    output wire [31:0] exe_rdata_o,
    output wire exe_rvalid_o,
    output wire exe_done_o,
    // Address generation
    input wire [31:0] agen_base_i,
    input wire [31:0] agen_off_i,
    output reg [31:0] agen_addr_o,
    // Memory reference check
    input wire mref_valid_i,
    input wire [1:0] mref_addr_lo_i,
    input wire [1:0] mref_size_i,
    input wire [31:0] eflags_i,
    input wire [31:0] control_reg_zero_i,
    // Page translation miss
    input wire pg_miss_i,
    // Task switch
    input wire ts_valid_i,
    input wire ts_legacy_i,
    input wire [31:0] ts_pdb_i,
    output reg [31:0] page_directory_base_o,
    // Descriptor load
    input wire dl_valid_i,
    input wire [7:0] dl_ar_i,
    input wire [15:0] dl_hi_i,
    input wire [31:0] dl_addr_i,
    output reg [7:0] desc_base_hi_o,
    output reg [3:0] desc_limit_hi_o,
    output reg dl_ok_o,
    // Faults and interrupt
    output reg fault_o,
    output reg [7:0] fault_vec_o,
    output reg irq_o,
    // Memory bus
    input wire mem_ack_i,
    input wire [31:0] mem_rdata_i,
    output wire mem_req_o,
    output wire mem_we_o,
    output wire [31:0] mem_addr_o,
    output wire [31:0] mem_wdata_o,
    output wire bus_lock_o
);

    reg [31:0] ctrl_r;
    reg [`LCC_ST_W-1:0] stat_r;
    reg [`LCC_ST_W-1:0] stat_nxt;
    reg [`LCC_ST_W-1:0] mask_r;
    reg [7:0] last_vec_r;
    reg [31:0] pdb_r;
    wire seq_busy;
    wire seq_done;
    wire [31:0] seq_rdata;
    wire seq_rvalid;

    // ==========================================
    // Decode-time lock legality
    wire lockable = (dec_op_i <= `LCC_OP_XOR); // RL2
    // No privilege input takes part in this check
    wire dec_take = dec_valid_i & dec_ready_o;
    wire ud_hit = dec_take & dec_lock_i &
        (~lockable | dec_dst_reg_i); // RL3 RL4 RL7
    wire swap_mem = (dec_op_i == `LCC_OP_SWAP) & ~dec_dst_reg_i;
    wire lock_go = dec_take & ~ud_hit & ~dec_dst_reg_i &
        (dec_lock_i | swap_mem); // RL5 RL16

    // ==========================================
    // Descriptor load checks
    wire dl_take = dl_valid_i & dec_ready_o & ~dec_valid_i;
    wire dl_bad = dl_take &
        ((dl_ar_i == `LCC_AR_BAD_A) | (dl_ar_i == `LCC_AR_BAD_B)); // RL1
    wire dl_good = dl_take & ~dl_bad;
    wire dl_lock = dl_good & ~dl_ar_i[`LCC_AR_ACC_BIT]; // RL13

    // ==========================================
    // Alignment and paging checks
    wire ac_on = eflags_i[`LCC_FLAG_AC_BIT] &
        control_reg_zero_i[`LCC_CR0_AM_BIT]; // RL11
    reg unaligned;
    always @* begin
        case (mref_size_i)
            2'h1: unaligned = mref_addr_lo_i[0];
            2'h2: unaligned = |mref_addr_lo_i;
            default: unaligned = 1'b0;
        endcase
    end
    wire ac_hit = mref_valid_i & ac_on & unaligned; // RL12
    wire pf_hit = pg_miss_i & ctrl_r[`LCC_CTRL_PG_BIT]; // RL9

    // ==========================================
    // Locked sequencer
    lcc_lock_seq u_seq (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .start_i(lock_go | dl_lock),
        .desc_i(dl_lock),
        .addr_i(dl_lock ? dl_addr_i : dec_addr_i),
        .wdata_i(exe_wdata_i),
        .wvalid_i(exe_wvalid_i),
        .mem_ack_i(mem_ack_i),
        .mem_rdata_i(mem_rdata_i),
        .mem_req_o(mem_req_o),
        .mem_we_o(mem_we_o),
        .mem_addr_o(mem_addr_o),
        .mem_wdata_o(mem_wdata_o),
        .bus_lock_o(bus_lock_o),
        .busy_o(seq_busy),
        .rdata_o(seq_rdata),
        .rvalid_o(seq_rvalid),
        .done_o(seq_done)
    );
    assign exe_rdata_o = seq_rdata;
    assign exe_rvalid_o = seq_rvalid;
    assign exe_done_o = seq_done;

    // ==========================================
    // Datapath outputs
    always @(posedge clk_i) begin
        if (rst_i) begin
            dec_ready_o <= 1'b0;
            dec_accept_o <= 1'b0;
            agen_addr_o <= 32'h0000_0000;
            pdb_r <= `LCC_PDB_RST;
            page_directory_base_o <= `LCC_PDB_RST;
            desc_base_hi_o <= 8'h00;
            desc_limit_hi_o <= 4'h0;
            dl_ok_o <= 1'b0;
        end else begin
            dec_ready_o <= ~seq_busy & ~lock_go & ~dl_lock;
            dec_accept_o <= dec_take & ~ud_hit;
            agen_addr_o <= agen_base_i + agen_off_i; // RL8
            if (ts_valid_i & ~ts_legacy_i) begin
                pdb_r <= ts_pdb_i; // RL10
                page_directory_base_o <= ts_pdb_i;
            end
            dl_ok_o <= dl_good;
            if (dl_good) begin
                desc_base_hi_o <= dl_hi_i[15:8]; // RL14
                desc_limit_hi_o <= dl_hi_i[3:0]; // RL14
            end
        end
    end

    // ==========================================
    // Fault reporting, highest priority first
    always @(posedge clk_i) begin
        if (rst_i) begin
            fault_o <= 1'b0;
            fault_vec_o <= 8'h00;
            last_vec_r <= 8'h00;
        end else begin
            fault_o <= ud_hit | dl_bad | ac_hit | pf_hit;
            if (ud_hit) begin
                fault_vec_o <= `LCC_VEC_UD; // RL3
                last_vec_r <= `LCC_VEC_UD;
            end else if (dl_bad) begin
                fault_vec_o <= `LCC_VEC_GP;
                last_vec_r <= `LCC_VEC_GP;
            end else if (ac_hit) begin
                fault_vec_o <= `LCC_VEC_AC; // RL12
                last_vec_r <= `LCC_VEC_AC;
            end else if (pf_hit) begin
                fault_vec_o <= `LCC_VEC_PF; // RL9
                last_vec_r <= `LCC_VEC_PF;
            end
        end
    end

    // ==========================================
    // Wishbone register file
    wire wb_hit = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire wb_wr = wb_hit & wb_we_i & wb_sel_i[0];
    wire [`LCC_ST_W-1:0] ev = {seq_done, pf_hit, ac_hit, dl_bad, ud_hit};

    always @* begin
        stat_nxt = stat_r;
        if (wb_wr && wb_adr_i == `LCC_REG_STAT) begin
            stat_nxt = stat_r & ~wb_dat_i[`LCC_ST_W-1:0];
        end
        stat_nxt = stat_nxt | ev;
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_r <= `LCC_CTRL_RST;
            mask_r <= `LCC_MASK_RST;
            stat_r <= {`LCC_ST_W{1'b0}};
            irq_o <= 1'b0;
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            stat_r <= stat_nxt;
            irq_o <= |(stat_r & mask_r);
            wb_ack_o <= wb_hit;
            if (wb_wr && wb_adr_i == `LCC_REG_CTRL) begin
                ctrl_r <= {31'h0000_0000, wb_dat_i[`LCC_CTRL_PG_BIT]};
            end
            if (wb_wr && wb_adr_i == `LCC_REG_MASK) begin
                mask_r <= wb_dat_i[`LCC_ST_W-1:0];
            end
            wb_dat_o <= 32'h0000_0000;
            if (wb_hit & ~wb_we_i) begin
                case (wb_adr_i)
                    `LCC_REG_CTRL: wb_dat_o <= ctrl_r;
                    `LCC_REG_STAT: wb_dat_o <= {27'h0000000, stat_r};
                    `LCC_REG_MASK: wb_dat_o <= {27'h0000000, mask_r};
                    `LCC_REG_FVEC: wb_dat_o <= {24'h000000, last_vec_r};
                    `LCC_REG_PDB: wb_dat_o <= pdb_r;
                    default: wb_dat_o <= 32'h0000_0000;
                endcase
            end
        end
    end

endmodule

// file: hw/lcc_defines.vh
`ifndef LCC_DEFINES_VH
`define LCC_DEFINES_VH

// ==========================================
// Register byte offsets
`define LCC_REG_CTRL 8'h00
`define LCC_REG_STAT 8'h04
`define LCC_REG_MASK 8'h08
`define LCC_REG_FVEC 8'h0c
`define LCC_REG_PDB 8'h10

// ==========================================
// Register fields and reset values
`define LCC_CTRL_PG_BIT 0
`define LCC_CTRL_RST 32'h0000_0000
`define LCC_MASK_RST 5'h00
`define LCC_PDB_RST 32'h0000_0000
`define LCC_ST_UD 0
`define LCC_ST_DESC 1
`define LCC_ST_AC 2
`define LCC_ST_PF 3
`define LCC_ST_LOCK 4
`define LCC_ST_W 5

// ==========================================
// Fault vectors
`define LCC_VEC_UD 8'h06
`define LCC_VEC_GP 8'h0d
`define LCC_VEC_PF 8'h0e
`define LCC_VEC_AC 8'h11

// ==========================================
// Flag and descriptor fields
`define LCC_FLAG_AC_BIT 18
`define LCC_CR0_AM_BIT 18
`define LCC_AR_BAD_A 8'h80
`define LCC_AR_BAD_B 8'h00
`define LCC_AR_ACC_BIT 0
`define LCC_DW_ACC_BIT 8

// ==========================================
// Operation classes; all up to XOR are lockable
`define LCC_OP_BTS 5'h00
`define LCC_OP_BTR 5'h01
`define LCC_OP_BTC 5'h02
`define LCC_OP_SWAP 5'h03
`define LCC_OP_EXCHANGE_AND_SUM_OP 5'h04
`define LCC_OP_COMPARE_AND_SWAP_OP 5'h05
`define LCC_OP_INC 5'h06
`define LCC_OP_DEC 5'h07
`define LCC_OP_NOT 5'h08
`define LCC_OP_NEG 5'h09
`define LCC_OP_ADD 5'h0a
`define LCC_OP_ADC 5'h0b
`define LCC_OP_SUB 5'h0c
`define LCC_OP_SBB 5'h0d
`define LCC_OP_AND 5'h0e
`define LCC_OP_OR 5'h0f
`define LCC_OP_XOR 5'h10

`endif

// file: hw/lcc_lock_seq.v
`timescale 1ns/1ps
`include "lcc_defines.vh"

module lcc_lock_seq (
    // Clock and reset
    input wire clk_i,
    input wire rst_i,
    // Start request
    input wire start_i,
    input wire desc_i,
    input wire [31:0] addr_i,
    // Write half from the execution side
    input wire [31:0] wdata_i,
    input wire wvalid_i,
    // Memory bus
    input wire mem_ack_i,
    input wire [31:0] mem_rdata_i,
    output reg mem_req_o,
    output reg mem_we_o,
    output reg [31:0] mem_addr_o,
    output reg [31:0] mem_wdata_o,
    output reg bus_lock_o,
    // Status back to the caller
    output reg busy_o,
    output reg [31:0] rdata_o,
    output reg rvalid_o,
    output reg done_o
);

    localparam S_IDLE = 4'b0001;
    localparam S_RD = 4'b0010;
    localparam S_WAITW = 4'b0100;
    localparam S_WR = 4'b1000;

    reg [3:0] state_r;
    reg desc_r;

    // ==========================================
    // Locked read-modify-write
    always @(posedge clk_i) begin
        if (rst_i) begin
            state_r <= S_IDLE;
            desc_r <= 1'b0;
            mem_req_o <= 1'b0;
            mem_we_o <= 1'b0;
            mem_addr_o <= 32'h0000_0000;
            mem_wdata_o <= 32'h0000_0000;
            bus_lock_o <= 1'b0;
            busy_o <= 1'b0;
            rdata_o <= 32'h0000_0000;
            rvalid_o <= 1'b0;
            done_o <= 1'b0;
        end else begin
            rvalid_o <= 1'b0;
            done_o <= 1'b0;
            case (state_r)
                S_IDLE: begin
                    if (start_i) begin
                        desc_r <= desc_i;
                        mem_req_o <= 1'b1;
                        mem_we_o <= 1'b0;
                        mem_addr_o <= addr_i; // RL6
                        bus_lock_o <= 1'b1; // RL15
                        busy_o <= 1'b1;
                        state_r <= S_RD;
                    end
                end
                S_RD: begin
                    if (mem_ack_i) begin
                        rdata_o <= mem_rdata_i;
                        if (desc_r) begin
                            mem_we_o <= 1'b1;
                            mem_wdata_o <= mem_rdata_i |
                                (32'h0000_0001 << `LCC_DW_ACC_BIT); // RL13
                            state_r <= S_WR;
                        end else begin
                            mem_req_o <= 1'b0;
                            rvalid_o <= 1'b1;
                            state_r <= S_WAITW;
                        end
                    end
                end
                S_WAITW: begin
                    if (wvalid_i) begin
                        mem_req_o <= 1'b1;
                        mem_we_o <= 1'b1;
                        mem_wdata_o <= wdata_i;
                        state_r <= S_WR;
                    end
                end
                S_WR: begin
                    if (mem_ack_i) begin
                        mem_req_o <= 1'b0;
                        mem_we_o <= 1'b0;
                        bus_lock_o <= 1'b0; // RL15
                        busy_o <= 1'b0;
                        done_o <= 1'b1;
                        state_r <= S_IDLE;
                    end
                end
                default: begin
                    state_r <= S_IDLE;
                end
            endcase
        end
    end

endmodule

// file: testbench/lcc_top_properties.sv
`timescale 1ns/1ps
// ==========
// Lock and fault timing
module lcc_top_properties (
    // Watched ports
    input wire clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_ack_o, fault_o,
    input wire dec_valid_i, dec_lock_i, dec_dst_reg_i, dec_ready_o,
    input wire mem_req_o, mem_we_o, mem_ack_i, bus_lock_o, dl_ok_o,
    input wire dl_valid_i, ts_valid_i, ts_legacy_i,
    input wire [4:0] dec_op_i,
    input wire [7:0] fault_vec_o, dl_ar_i,
    input wire [31:0] page_directory_base_o
);
    wire dl_take = dl_valid_i && dec_ready_o && !dec_valid_i;
    wire ar_bad = dl_ar_i == 8'h80 || dl_ar_i == 8'h00;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence take_s;
        dec_valid_i && dec_ready_o;
    endsequence
    sequence bad_s;
        take_s ##0 (dec_lock_i && (dec_dst_reg_i || dec_op_i > 5'h10));
    endsequence
    sequence locked_s;
        take_s ##0 (!dec_dst_reg_i && dec_op_i <= 5'h10
            && (dec_lock_i || dec_op_i == 5'h03));
    endsequence
    wb_ack_a:
        assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
            |=> wb_ack_o ##1 !wb_ack_o) else $error("Bus ack timing");
    ud_fault_a:
        assert property (bad_s |=> fault_o && fault_vec_o == 8'h06)
        else $error("Illegal lock not refused");
    no_bus_a:
        assert property (bad_s |=> !mem_req_o && !bus_lock_o)
        else $error("Refused op reached the bus");
    lock_start_a:
        assert property (locked_s |=> mem_req_o && !mem_we_o
            && bus_lock_o && !dec_ready_o) else $error("No locked read");
    lock_hold_a:
        assert property (bus_lock_o && !mem_we_o && mem_ack_i
            |=> bus_lock_o [*2]) else $error("Lock lost after read");
    lock_drop_a:
        assert property (bus_lock_o && mem_we_o && mem_ack_i
            |=> !bus_lock_o && !mem_req_o) else $error("Lock kept");
    bad_desc_a:
        assert property (dl_take && ar_bad |=> fault_o
            && fault_vec_o == 8'h0d && !dl_ok_o) else $error("Bad ar taken");
    acc_set_a:
        assert property (dl_take && !ar_bad && dl_ar_i[0]
            |=> dl_ok_o && !mem_req_o) else $error("Needless locked cycle");
    acc_clr_a:
        assert property (dl_take && !ar_bad && !dl_ar_i[0]
            |=> mem_req_o && bus_lock_o) else $error("Accessed bit not set");
    pdb_keep_a:
        assert property (ts_valid_i && ts_legacy_i
            |=> $stable(page_directory_base_o)) else $error("Base changed");
endmodule

// file: testbench/lcc_mem_model.sv
`timescale 1ns/1ps
// ==========
// Shared memory on the far side
module lcc_mem_model (
    // Bus from the block
    input wire clk_i, rst_i, req_i, we_i,
    input wire [31:0] addr_i, wdata_i,
    input wire [1:0] wait_i,
    // Answer
    output logic ack_o,
    output logic [31:0] rdata_o
);
    logic [31:0] mem [0:255];
    logic [1:0] cnt;
    initial begin
        for (int i = 0; i < 256; i++)
            mem[i] = i * 32'h0101_0101;
        rdata_o = 32'h0;
        ack_o = 1'b0;
    end
    // Released data toggles; no other master enters while locked
    always @(posedge clk_i) begin
        ack_o <= 1'b0;
        rdata_o <= ~rdata_o;
        if (rst_i) begin
            cnt <= 2'h0;
        end else if (req_i && !ack_o) begin
            cnt <= cnt + 2'h1;
            if (cnt == wait_i) begin
                ack_o <= 1'b1;
                cnt <= 2'h0;
                if (we_i)
                    mem[addr_i[9:2]] <= wdata_i;
                else
                    rdata_o <= mem[addr_i[9:2]];
            end
        end
    end
endmodule

// file: testbench/lcc_top_tb.sv
`timescale 1ns/1ps
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin miscompares++; \
$display("[FAIL] %0t got %h exp %h", $time, a, e); end end
`define WAITC(c) begin n = 0; while ((c) !== 1'b1 && n < 200) begin \
@(posedge clk_i); n++; end if (n >= 200) begin miscompares++; \
give_verdict; end end
module lcc_top_tb;
    logic clk_i = 0, rst_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
    logic dec_valid_i = 0, dec_lock_i = 0, dec_dst_reg_i = 0, fa;
    logic exe_wvalid_i = 0, mref_valid_i = 0, pg_miss_i = 0, mem_ack_i;
    logic ts_valid_i = 0, ts_legacy_i = 0, dl_valid_i = 0;
    logic [3:0] wb_sel_i = 0, desc_limit_hi_o;
    logic [4:0] dec_op_i = 0;
    logic [7:0] wb_adr_i = 0, dl_ar_i = 0, desc_base_hi_o, fault_vec_o;
    logic [1:0] mref_addr_lo_i = 0, mref_size_i = 0, mem_wait = 0;
    logic [15:0] dl_hi_i = 0;
    logic [31:0] wb_dat_i = 0, dec_addr_i = 0, exe_wdata_i = 0;
    logic [31:0] agen_base_i = 0, agen_off_i = 0, eflags_i = 0;
    logic [31:0] control_reg_zero_i = 0, ts_pdb_i = 0, dl_addr_i = 0;
    logic [31:0] mem_rdata_i, wb_dat_o, exe_rdata_o, agen_addr_o, q, r;
    logic [31:0] page_directory_base_o, mem_addr_o, mem_wdata_o;
    logic wb_ack_o, dec_ready_o, dec_accept_o, exe_rvalid_o, exe_done_o;
    logic dl_ok_o, fault_o, irq_o, mem_req_o, mem_we_o, bus_lock_o;
    logic [31:0] exp_mem [0:255];
    logic [7:0] ars [0:5] = '{8'h80, 8'h00, 8'h93, 8'h92, 8'hf2, 8'hf3};
    int checked = 0, miscompares = 0, seed = 32'h14f2b838, n;
    lcc_top u_dut (.*);
    lcc_mem_model u_mem (
        .clk_i(clk_i), .rst_i(rst_i), .req_i(mem_req_o), .we_i(mem_we_o),
        .addr_i(mem_addr_o), .wdata_i(mem_wdata_o), .wait_i(mem_wait),
        .ack_o(mem_ack_i), .rdata_o(mem_rdata_i)
    );
    always #10 clk_i = ~clk_i;
    task give_verdict;
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // ==========
    // Bus cycles
    task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_dat_i <= d;
        wb_sel_i <= 4'hf;
        `WAITC(wb_ack_o)
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask
    task dec(input logic [4:0] o, input logic lk, input logic dr);
        logic [31:0] a, wd, old;
        logic f, ls;
        a = $random(seed) & 32'h3fc;
        wd = $random(seed);
        f = lk && (dr || o > 5'h10);
        ls = !f && !dr && o <= 5'h10 && (lk || o == 5'h03);
        mem_wait <= wd[1:0];
        `WAITC(dec_ready_o)
        dec_valid_i <= 1'b1;
        dec_op_i <= o;
        dec_lock_i <= lk;
        dec_dst_reg_i <= dr;
        dec_addr_i <= a;
        @(posedge clk_i);
        dec_valid_i <= 1'b0;
        @(posedge clk_i);
        `CHK(fault_o, f)
        `CHK(dec_accept_o, !f)
        `CHK(bus_lock_o, ls)
        if (f)
            `CHK(fault_vec_o, 8'h06)
        if (ls) begin
            old = exp_mem[a[9:2]];
            `WAITC(exe_rvalid_o)
            `CHK(exe_rdata_o, old)
            exe_wdata_i <= wd;
            exe_wvalid_i <= 1'b1;
            `WAITC(exe_done_o)
            exe_wvalid_i <= 1'b0;
            exp_mem[a[9:2]] = wd;
            `CHK(u_mem.mem[a[9:2]], wd)
        end
    endtask
    task dl(input logic [7:0] ar);
        logic [31:0] a;
        logic bad;
        logic [15:0] h;
        a = $random(seed) & 32'h3fc;
        h = 16'($random(seed));
        bad = ar == 8'h80 || ar == 8'h00;
        dl_ar_i <= ar;
        dl_hi_i <= h;
        dl_addr_i <= a;
        `WAITC(dec_ready_o)
        dl_valid_i <= 1'b1;
        @(posedge clk_i);
        dl_valid_i <= 1'b0;
        @(posedge clk_i);
        `CHK(fault_o, bad)
        `CHK(mem_req_o, !bad && !ar[0])
        `CHK(dl_ok_o, !bad)
        if (!bad) begin
            `CHK(desc_base_hi_o, h[15:8])
            `CHK(desc_limit_hi_o, h[3:0])
        end
        `WAITC(!bus_lock_o)
        if (!bad && !ar[0])
            exp_mem[a[9:2]] = exp_mem[a[9:2]] | 32'h100;
        `CHK(u_mem.mem[a[9:2]], exp_mem[a[9:2]])
    endtask
    // ==========
    // Main sequence
    initial begin
        for (int i = 0; i < 256; i++)
            exp_mem[i] = i * 32'h0101_0101;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(1'b0, 8'h10, 32'h0);
        `CHK(q, 32'h0)
        wb(1'b1, 8'h08, 32'h1f);
        wb(1'b1, 8'h00, 32'h1);
        wb(1'b0, 8'h40, 32'h0);
        `CHK(q, 32'h0)
        for (int o = 0; o < 24; o++)
            for (int k = 0; k < 4; k++)
                dec(o[4:0], k[0], k[1]);
        agen_base_i <= 32'h00ff_fff0;
        agen_off_i <= 32'h20;
        repeat (2) @(posedge clk_i);
        `CHK(agen_addr_o, 32'h0100_0010)
        for (int i = 0; i < 32; i++) begin
            r = $random(seed);
            eflags_i <= r;
            control_reg_zero_i <= {r[15:0], r[31:16]};
            mref_size_i <= r[4:3];
            mref_addr_lo_i <= r[6:5];
            mref_valid_i <= 1'b1;
            @(posedge clk_i);
            mref_valid_i <= 1'b0;
            @(posedge clk_i);
            fa = r[18] && r[2] && (r[4:3] == 2'h1 && r[5]
                || r[4:3] == 2'h2 && r[6:5] != 2'h0);
            `CHK(fault_o, fa)
            if (fa)
                `CHK(fault_vec_o, 8'h11)
        end
        wb(1'b1, 8'h04, 32'h1f);
        repeat (2) @(posedge clk_i);
        `CHK(irq_o, 1'b0)
        pg_miss_i <= 1'b1;
        @(posedge clk_i);
        pg_miss_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        `CHK(fault_vec_o, 8'h0e)
        `CHK(irq_o, 1'b1)
        wb(1'b0, 8'h04, 32'h0);
        `CHK(q, 32'h8)
        wb(1'b1, 8'h08, 32'h0);
        repeat (2) @(posedge clk_i);
        `CHK(irq_o, 1'b0)
        wb(1'b1, 8'h00, 32'h0);
        pg_miss_i <= 1'b1;
        @(posedge clk_i);
        pg_miss_i <= 1'b0;
        @(posedge clk_i);
        `CHK(fault_o, 1'b0)
        for (int k = 0; k < 2; k++) begin
            ts_pdb_i <= 32'h1000 << k;
            ts_legacy_i <= k[0];
            ts_valid_i <= 1'b1;
            @(posedge clk_i);
            ts_valid_i <= 1'b0;
            @(posedge clk_i);
            `CHK(page_directory_base_o, 32'h1000)
        end
        for (int i = 0; i < 6; i++)
            dl(ars[i]);
        give_verdict;
    end
endmodule
bind lcc_top lcc_top_properties u_props (.*);
